// ===== verilog/dtc_pkg.sv
package dtc_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [7:0] DTC_TIMER_A_COUNTER = 8'hCA;
  localparam logic [7:0] DTC_TIMER_A_CONTROL = 8'hCB;
  localparam logic [7:0] DTC_TIMER_A_CH0_CONTROL = 8'hCC;
  localparam logic [7:0] DTC_TIMER_A_CH0_COMPARE_VALUE = 8'hCD;
  localparam logic [7:0] DTC_TIMER_A_CH1_CONTROL = 8'hCE;
  localparam logic [7:0] DTC_TIMER_A_CH1_COMPARE_VALUE = 8'hCF;
  localparam logic [7:0] DTC_TIMER_FLAGS_AND_MASK = 8'hD8;
  localparam logic [7:0] DTC_TIMER_B_COUNTER = 8'hEA;
  localparam logic [7:0] DTC_TIMER_B_CONTROL = 8'hEB;
  localparam logic [7:0] DTC_TIMER_B_CH0_CONTROL = 8'hEC;
  localparam logic [7:0] DTC_TIMER_B_CH0_COMPARE_VALUE = 8'hED;
  localparam logic [7:0] DTC_TIMER_B_CH1_CONTROL = 8'hEE;
  localparam logic [7:0] DTC_TIMER_B_CH1_COMPARE_VALUE = 8'hEF;

  // Each timer occupies six consecutive addresses starting at its counter.
  localparam logic [1:0][7:0] DTC_TIMER_BASE = {DTC_TIMER_B_COUNTER, DTC_TIMER_A_COUNTER};
  localparam logic [7:0] DTC_REG_COUNTER = 8'h00;
  localparam logic [7:0] DTC_REG_CONTROL = 8'h01;
  localparam logic [7:0] DTC_REG_CH0_CONTROL = 8'h02;
  localparam logic [7:0] DTC_REG_CH0_VALUE = 8'h03;
  localparam logic [7:0] DTC_REG_CH1_CONTROL = 8'h04;
  localparam logic [7:0] DTC_REG_CH1_VALUE = 8'h05;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DTC_CTL_DIV_LSB = 5;
  localparam int DTC_CTL_START_BIT = 4;
  localparam int DTC_CTL_OVERFLOW_IRQ_MASK_BIT = 3;
  localparam int DTC_CTL_CLEAR_BIT = 2;
  localparam int DTC_CTL_MODE_LSB = 0;
  localparam int DTC_CH_IM_BIT = 6;
  localparam int DTC_CH_ACT_LSB = 3;
  localparam int DTC_CH_EN_BIT = 2;
  localparam int DTC_CH_RSV_LSB = 0;
  localparam int DTC_FLAG_OTHER_MASK_BIT = 6;
  localparam int DTC_FLAG_OVF = 0;
  localparam int DTC_FLAG_CH0 = 1;
  localparam int DTC_FLAG_CH1 = 2;
  localparam int DTC_FLAGS_PER_TIMER = 3;

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic [7:0] DTC_VALUE_RESET = 8'h00;
  localparam logic [7:0] DTC_COUNT_ZERO = 8'h00;
  localparam logic [7:0] DTC_COUNT_MAX = 8'hFF;
  localparam logic [7:0] DTC_COUNT_ONE = 8'h01;
  localparam int DTC_PRESCALE_W = 7;
  localparam logic [6:0] DTC_PRESCALE_ALL = 7'h7F;
  localparam logic [2:0] DTC_DIV_MAX = 3'h7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    DTC_MODE_FREE = 2'b00,
    DTC_MODE_DOWN = 2'b01,
    DTC_MODE_MODULO = 2'b10,
    DTC_MODE_UPDOWN = 2'b11
  } dtc_mode_t;

  typedef enum logic [2:0] {
    DTC_ACT_SET = 3'b000,
    DTC_ACT_CLEAR = 3'b001,
    DTC_ACT_TOGGLE = 3'b010,
    DTC_ACT_SET_UP = 3'b011,
    DTC_ACT_CLEAR_UP = 3'b100,
    DTC_ACT_SET_ALT = 3'b101,
    DTC_ACT_CLEAR_ALT = 3'b110,
    DTC_ACT_UNUSED = 3'b111
  } dtc_action_t;

  typedef struct packed {
    logic irq_mask;
    dtc_action_t action;
    logic enable;
    logic [1:0] reserved;
    logic out;
  } dtc_chan_t;

  typedef struct packed {
    logic [2:0] div;
    logic run;
    logic overflow_irq_mask;
    dtc_mode_t mode;
    logic [7:0] count;
    logic count_down;
    logic [DTC_PRESCALE_W-1:0] prescale;
    logic [7:0] cc0_value;
    logic [7:0] cc0_active;
    logic [7:0] cc1_value;
    dtc_chan_t [1:0] chan;
  } dtc_timer_t;

  typedef struct packed {
    dtc_timer_t [1:0] timer;
    logic [5:0] flags;
    logic other_overflow_mask;
    logic [7:0] rdata;
    logic [1:0] irq;
  } dtc_state_t;

  localparam dtc_chan_t DTC_CHAN_RESET = '{
    irq_mask: 1'b1, action: DTC_ACT_SET, enable: 1'b0, reserved: 2'b00, out: 1'b0};
  localparam dtc_timer_t DTC_TIMER_RESET = '{
    div: 3'h0, run: 1'b0, overflow_irq_mask: 1'b1, mode: DTC_MODE_FREE,
    count: DTC_VALUE_RESET, count_down: 1'b0, prescale: 7'h00,
    cc0_value: DTC_VALUE_RESET, cc0_active: DTC_VALUE_RESET, cc1_value: DTC_VALUE_RESET,
    chan: {DTC_CHAN_RESET, DTC_CHAN_RESET}};
  localparam dtc_state_t DTC_STATE_RESET = '{
    timer: {DTC_TIMER_RESET, DTC_TIMER_RESET}, flags: 6'h00, other_overflow_mask: 1'b1,
    rdata: DTC_VALUE_RESET, irq: 2'b00};

endpackage

// ===== verilog/dtc_timers.sv
`timescale 1ns/1ps

// How it works
// - Active edges every 2 to the prescaler code ticks.
// - Prescaler change alters edge rate at once.
// - Counter advances only while run bit set.
// - Clear bit zeroes counter and reads zero.
// - Clear bit reads zero after deep sleep.
// - Mode 00 counts up, wraps after 0xFF.
// - Mode 01 loads channel-0 value, counts down.
// - Mode 10 counts up to channel-0 value, reloads.
// - Mode 11 counts up to value, then down.
// - Compare actions happen only when channel enabled.
// - Match sets, clears or toggles for 000-010.
// - Code 011 sets on up-match, clears later.
// - Code 100 clears on up-match, sets later.
// - Channel 0 codes 101/110 use 0xFF/zero.
// - Channel 1 codes 101/110 use channel-0 match.
// - Channel mask gates interrupt, resets enabled.
// - Overflow interrupt needs mask and CPU enable.
// - Flags set regardless of masks.
// - Flag register layout: timer A then B.
// - Writing 0 clears a flag, 1 ignored.
// - Counter register reads live count.
// - Compare values readable, writable, reset zero.
// - Channel-0 value used after counter hits zero.
module dtc_timers
  import dtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_timer_a_enable,
  input wire logic cpu_timer_b_enable,
  output logic timer_a_irq,
  output logic timer_b_irq,
  output logic [1:0] timer_a_cmp_out,
  output logic [1:0] timer_b_cmp_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  dtc_state_t s;
  dtc_state_t next_s;
  logic [1:0] cpu_enable;

  assign cpu_enable = {cpu_timer_b_enable, cpu_timer_a_enable};

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    dtc_timer_t tm;
    logic [6:0] div_mask;
    logic edge_now;
    logic [7:0] nxt;
    logic nxt_down;
    logic ovf_ev;
    logic arrive;
    logic arr_up;
    logic m0;
    logic m1;
    logic zero_ev;
    logic full_ev;
    logic match;
    logic alt_ev;
    logic [7:0] ofs;
    logic hit;
    logic [5:0] flag_set;
    logic [7:0] rd;
    tm = '0;
    div_mask = '0;
    edge_now = 1'b0;
    nxt = '0;
    nxt_down = 1'b0;
    ovf_ev = 1'b0;
    arrive = 1'b0;
    arr_up = 1'b0;
    m0 = 1'b0;
    m1 = 1'b0;
    zero_ev = 1'b0;
    full_ev = 1'b0;
    match = 1'b0;
    alt_ev = 1'b0;
    ofs = '0;
    hit = 1'b0;
    flag_set = '0;
    rd = DTC_VALUE_RESET;
    next_s = s;

    for (int t = 0; t < 2; t++) begin
      tm = s.timer[t];
      ofs = sfr_addr - DTC_TIMER_BASE[t];
      hit = (sfr_addr >= DTC_TIMER_BASE[t]) && (ofs <= DTC_REG_CH1_VALUE);

      // The buffered value only moves while the count sits at zero.
      if (s.timer[t].count == DTC_COUNT_ZERO) begin
        tm.cc0_active = s.timer[t].cc0_value;
      end

      // The mask is taken from the live divider code, so a change acts on the next tick.
      div_mask = DTC_PRESCALE_ALL >> (DTC_DIV_MAX - s.timer[t].div);
      edge_now = s.timer[t].run && tick
        && ((s.timer[t].prescale & div_mask) == 7'h00);
      if (s.timer[t].run && tick) begin
        tm.prescale = s.timer[t].prescale + 7'h01;
      end

      nxt = s.timer[t].count;
      nxt_down = s.timer[t].count_down;
      ovf_ev = 1'b0;
      if (edge_now) begin
        case (s.timer[t].mode)
          DTC_MODE_FREE: begin
            nxt = s.timer[t].count + DTC_COUNT_ONE;
            ovf_ev = (s.timer[t].count == DTC_COUNT_MAX);
          end
          DTC_MODE_DOWN: begin
            if (s.timer[t].count != DTC_COUNT_ZERO) begin
              nxt = s.timer[t].count - DTC_COUNT_ONE;
              ovf_ev = (nxt == DTC_COUNT_ZERO);
            end
          end
          DTC_MODE_MODULO: begin
            if (s.timer[t].count == tm.cc0_active) begin
              nxt = DTC_COUNT_ZERO;
              ovf_ev = 1'b1;
            end else begin
              nxt = s.timer[t].count + DTC_COUNT_ONE;
            end
          end
          DTC_MODE_UPDOWN: begin
            if (s.timer[t].count_down || (s.timer[t].count == tm.cc0_active)) begin
              if (s.timer[t].count == DTC_COUNT_ZERO) begin
                ovf_ev = 1'b1;
                nxt_down = 1'b0;
              end else begin
                nxt = s.timer[t].count - DTC_COUNT_ONE;
                nxt_down = (nxt != DTC_COUNT_ZERO);
                ovf_ev = (nxt == DTC_COUNT_ZERO);
              end
            end else begin
              nxt = s.timer[t].count + DTC_COUNT_ONE;
            end
          end
          default: begin
            nxt = s.timer[t].count;
          end
        endcase
      end
      tm.count = nxt;
      tm.count_down = nxt_down;

      // Events fire when the count moves onto a value, so a stalled count never repeats them.
      arrive = edge_now && (nxt != s.timer[t].count);
      arr_up = (nxt == s.timer[t].count + DTC_COUNT_ONE);
      m0 = arrive && (nxt == tm.cc0_active);
      m1 = arrive && (nxt == s.timer[t].cc1_value);
      zero_ev = arrive && (nxt == DTC_COUNT_ZERO);
      full_ev = arrive && (nxt == DTC_COUNT_MAX);

      for (int c = 0; c < 2; c++) begin
        match = (c == 0) ? m0 : m1;
        alt_ev = (c == 0) ? ((s.timer[t].chan[c].action == DTC_ACT_SET_ALT) ? full_ev : zero_ev)
          : m0;
        if (s.timer[t].chan[c].enable) begin
          case (s.timer[t].chan[c].action)
            DTC_ACT_SET: begin
              if (match) tm.chan[c].out = 1'b1;
            end
            DTC_ACT_CLEAR: begin
              if (match) tm.chan[c].out = 1'b0;
            end
            DTC_ACT_TOGGLE: begin
              if (match) tm.chan[c].out = !s.timer[t].chan[c].out;
            end
            DTC_ACT_SET_UP: begin
              if (s.timer[t].mode == DTC_MODE_UPDOWN) begin
                if (match) tm.chan[c].out = arr_up;
              end else begin
                if (zero_ev) tm.chan[c].out = 1'b0;
                if (match) tm.chan[c].out = 1'b1;
              end
            end
            DTC_ACT_CLEAR_UP: begin
              if (s.timer[t].mode == DTC_MODE_UPDOWN) begin
                if (match) tm.chan[c].out = !arr_up;
              end else begin
                if (zero_ev) tm.chan[c].out = 1'b1;
                if (match) tm.chan[c].out = 1'b0;
              end
            end
            DTC_ACT_SET_ALT: begin
              if (alt_ev) tm.chan[c].out = 1'b0;
              if (match) tm.chan[c].out = 1'b1;
            end
            DTC_ACT_CLEAR_ALT: begin
              if (alt_ev) tm.chan[c].out = 1'b1;
              if (match) tm.chan[c].out = 1'b0;
            end
            default: begin
              tm.chan[c].out = s.timer[t].chan[c].out;
            end
          endcase
        end
      end

      // Flags ignore every mask; masks only shape the request line.
      flag_set[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_OVF] = ovf_ev;
      flag_set[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_CH0] =
        (s.timer[t].mode == DTC_MODE_UPDOWN) ? ovf_ev : (m0 && s.timer[t].chan[0].enable);
      flag_set[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_CH1] = m1 && s.timer[t].chan[1].enable;

      // Software writes land after counting, so they override a same-cycle count step.
      if (sfr_wr && hit) begin
        case (ofs)
          DTC_REG_CONTROL: begin
            tm.div = sfr_wdata[DTC_CTL_DIV_LSB +: 3];
            tm.run = sfr_wdata[DTC_CTL_START_BIT];
            tm.overflow_irq_mask = sfr_wdata[DTC_CTL_OVERFLOW_IRQ_MASK_BIT];
            tm.mode = dtc_mode_t'(sfr_wdata[DTC_CTL_MODE_LSB +: 2]);
            if (sfr_wdata[DTC_CTL_START_BIT] && !s.timer[t].run
                && (sfr_wdata[DTC_CTL_MODE_LSB +: 2] == DTC_MODE_DOWN)) begin
              tm.count = s.timer[t].cc0_value;
            end
            if (sfr_wdata[DTC_CTL_CLEAR_BIT]) begin
              tm.count = DTC_COUNT_ZERO;
              tm.count_down = 1'b0;
            end
          end
          DTC_REG_CH0_CONTROL, DTC_REG_CH1_CONTROL: begin
            tm.chan[(ofs == DTC_REG_CH1_CONTROL) ? 1 : 0].irq_mask = sfr_wdata[DTC_CH_IM_BIT];
            tm.chan[(ofs == DTC_REG_CH1_CONTROL) ? 1 : 0].action =
              dtc_action_t'(sfr_wdata[DTC_CH_ACT_LSB +: 3]);
            tm.chan[(ofs == DTC_REG_CH1_CONTROL) ? 1 : 0].enable = sfr_wdata[DTC_CH_EN_BIT];
            tm.chan[(ofs == DTC_REG_CH1_CONTROL) ? 1 : 0].reserved =
              sfr_wdata[DTC_CH_RSV_LSB +: 2];
          end
          DTC_REG_CH0_VALUE: begin
            tm.cc0_value = sfr_wdata;
          end
          DTC_REG_CH1_VALUE: begin
            tm.cc1_value = sfr_wdata;
          end
          default: begin
            tm.cc1_value = tm.cc1_value;
          end
        endcase
      end

      if (hit) begin
        case (ofs)
          DTC_REG_COUNTER: rd = s.timer[t].count;
          DTC_REG_CONTROL: rd = {s.timer[t].div, s.timer[t].run,
            s.timer[t].overflow_irq_mask, 1'b0, s.timer[t].mode};
          DTC_REG_CH0_CONTROL: rd = {1'b0, s.timer[t].chan[0].irq_mask,
            s.timer[t].chan[0].action, s.timer[t].chan[0].enable, s.timer[t].chan[0].reserved};
          DTC_REG_CH0_VALUE: rd = s.timer[t].cc0_value;
          DTC_REG_CH1_CONTROL: rd = {1'b0, s.timer[t].chan[1].irq_mask,
            s.timer[t].chan[1].action, s.timer[t].chan[1].enable, s.timer[t].chan[1].reserved};
          DTC_REG_CH1_VALUE: rd = s.timer[t].cc1_value;
          default: rd = DTC_VALUE_RESET;
        endcase
      end

      next_s.timer[t] = tm;
    end

    // ========================================================================
    // Shared flag register
    // ========================================================================
    if (sfr_wr && (sfr_addr == DTC_TIMER_FLAGS_AND_MASK)) begin
      next_s.flags = s.flags & sfr_wdata[5:0];
      next_s.other_overflow_mask = sfr_wdata[DTC_FLAG_OTHER_MASK_BIT];
    end
    // A flag event in the same cycle as its clearing write still leaves the flag set.
    next_s.flags = next_s.flags | flag_set;
    if (sfr_addr == DTC_TIMER_FLAGS_AND_MASK) begin
      rd = {1'b0, s.other_overflow_mask, s.flags};
    end

    if (sfr_rd) begin
      next_s.rdata = rd;
    end

    for (int t = 0; t < 2; t++) begin
      next_s.irq[t] = cpu_enable[t] && (
        (next_s.flags[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_OVF]
          && next_s.timer[t].overflow_irq_mask)
        || (next_s.flags[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_CH0]
          && next_s.timer[t].chan[0].irq_mask)
        || (next_s.flags[t*DTC_FLAGS_PER_TIMER + DTC_FLAG_CH1]
          && next_s.timer[t].chan[1].irq_mask));
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= DTC_STATE_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.rdata;
  assign timer_a_irq = s.irq[0];
  assign timer_b_irq = s.irq[1];
  assign timer_a_cmp_out = {s.timer[0].chan[1].out, s.timer[0].chan[0].out};
  assign timer_b_cmp_out = {s.timer[1].chan[1].out, s.timer[1].chan[0].out};

endmodule

// ===== verif/dtc_tick_src.sv
`timescale 1ns/1ps

// ============================================================
// System tick source
// ============================================================
// Emits a burst of back-to-back ticks; the line is low between bursts.
module dtc_tick_src (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [9:0] n_tick,
  output logic tick
);
  logic [9:0] left;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 10'h000;
    end else if (go) begin
      left <= n_tick;
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
  end

  assign tick = (left != 10'h000);
endmodule

// ===== verif/dtc_timers_sva.sv
`timescale 1ns/1ps

// ============================================================
// Port checker
// ============================================================
module dtc_timers_sva
  import dtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic cpu_timer_a_enable,
  input wire logic cpu_timer_b_enable,
  input wire logic timer_a_irq,
  input wire logic timer_b_irq,
  input wire logic [1:0] timer_a_cmp_out,
  input wire logic [1:0] timer_b_cmp_out
);
  logic mapped;
  logic rd_take;

  assign mapped = (sfr_addr >= 8'hCA && sfr_addr <= 8'hCF) || sfr_addr == 8'hD8 ||
                  (sfr_addr >= 8'hEA && sfr_addr <= 8'hEF);
  assign rd_take = sfr_rd && ce;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_IRQ_A_GATED: assert property (!cpu_timer_a_enable && ce |=> !timer_a_irq)
    else $error("timer A interrupt without cpu enable");
  AST_IRQ_B_GATED: assert property (!cpu_timer_b_enable && ce |=> !timer_b_irq)
    else $error("timer B interrupt without cpu enable");
  AST_RDATA_HOLD: assert property (!rd_take |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (rd_take && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CLEAR_READS_ZERO: assert property (rd_take &&
    (sfr_addr == DTC_TIMER_A_CONTROL || sfr_addr == DTC_TIMER_B_CONTROL) |=> !sfr_rdata[2])
    else $error("clear bit read back as one");
  AST_BIT7_ZERO: assert property (rd_take &&
    sfr_addr inside {8'hCC, 8'hCE, 8'hD8, 8'hEC, 8'hEE} |=> !sfr_rdata[7])
    else $error("unused bit 7 read as one");
  AST_PINS_NEED_TICK: assert property (ce && !tick && !sfr_wr |=>
    $stable({timer_a_cmp_out, timer_b_cmp_out}))
    else $error("compare pin moved without a tick");
  AST_FLAGS_A_CLEARED: assert property (ce && !tick && sfr_wr && sfr_addr == 8'hD8 &&
    sfr_wdata[2:0] == 3'b000 |=> !timer_a_irq)
    else $error("timer A flags not cleared");
  AST_FLAGS_B_CLEARED: assert property (ce && !tick && sfr_wr && sfr_addr == 8'hD8 &&
    sfr_wdata[5:3] == 3'b000 |=> !timer_b_irq)
    else $error("timer B flags not cleared");
endmodule

bind dtc_timers dtc_timers_sva dtc_timers_sva_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .tick(tick), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .cpu_timer_a_enable(cpu_timer_a_enable),
  .cpu_timer_b_enable(cpu_timer_b_enable), .timer_a_irq(timer_a_irq),
  .timer_b_irq(timer_b_irq), .timer_a_cmp_out(timer_a_cmp_out),
  .timer_b_cmp_out(timer_b_cmp_out));

// ===== verif/dual_8bit_timer_compare_test.sv
`timescale 1ns/1ps

// ============================================================
// Testbench
// ============================================================
module dual_8bit_timer_compare_test;
  import dtc_pkg::*;
  logic mclk, rst_n, go, tick, sfr_wr, sfr_rd, cpu_a_en, cpu_b_en;
  logic timer_a_irq, timer_b_irq;
  logic [9:0] n_tick;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val, base, v;
  logic [1:0] timer_a_cmp_out, timer_b_cmp_out;
  logic [7:0] rst_tab [6] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00};
  int failures, n_tests, n, cc, ovf;

  dtc_timers dtc_timers_i (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .tick(tick),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .cpu_timer_a_enable(cpu_a_en), .cpu_timer_b_enable(cpu_b_en),
    .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq),
    .timer_a_cmp_out(timer_a_cmp_out), .timer_b_cmp_out(timer_b_cmp_out));
  dtc_tick_src dtc_tick_src_i (.mclk(mclk), .rst_n(rst_n), .go(go), .n_tick(n_tick),
    .tick(tick));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Reference count after n ticks from zero, one active edge per tick.
  function automatic int exp_count(int mode, int c, int k);
    case (mode)
      0: return k % 256;
      1: return (c > k) ? c - k : 0;
      2: return k % (c + 1);
      default: return ((k % (2 * c)) <= c) ? k % (2 * c) : 2 * c - k % (2 * c);
    endcase
  endfunction

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1 rd_val = sfr_rdata;
  endtask

  // The tick source ends each burst on its own, so the wait is exact.
  task automatic ticks(input int k);
    @(posedge mclk);
    go <= 1'b1;
    n_tick <= 10'(k);
    @(posedge mclk);
    go <= 1'b0;
    repeat (k + 1) @(posedge mclk);
  endtask

  task automatic reset_dut();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    // The whole run needs well under 6000 cycles; this leaves a wide margin.
    #100000;
    failures++;
    print_verdict();
  end

  initial begin
    {rst_n, go, sfr_wr, sfr_rd, cpu_a_en, cpu_b_en} = 6'b000011;
    {n_tick, sfr_addr, sfr_wdata} = '0;
    failures = 0;
    n_tests = 0;
    v = 8'($urandom(32'h69558bd8));
    reset_dut();
    for (int t = 0; t < 2; t++) begin
      base = t ? DTC_TIMER_B_COUNTER : DTC_TIMER_A_COUNTER;
      for (int o = 0; o < 6; o++) begin
        rd(base + 8'(o));
        chk("reset value", rst_tab[o], rd_val);
      end
      for (int o = 3; o < 6; o += 2) begin
        v = 8'($urandom);
        wr(base + 8'(o), v);
        rd(base + 8'(o));
        chk("compare value", v, rd_val);
      end
      wr(base, 8'h55);
      rd(base);
      chk("counter read only", 8'h00, rd_val);
    end
    rd(DTC_TIMER_FLAGS_AND_MASK);
    chk("flags reset", 8'h40, rd_val);
    rd(8'h00);
    chk("unmapped", 8'h00, rd_val);
    for (int d = 0; d < 8; d++) begin
      reset_dut();
      base = d[0] ? DTC_TIMER_B_COUNTER : DTC_TIMER_A_COUNTER;
      n = $urandom_range(1, 300);
      wr(base + 8'h01, 8'(d << 5) | 8'h10);
      ticks(n);
      wr(base + 8'h01, 8'h10);
      ticks(3);
      wr(base + 8'h01, 8'h00);
      ticks(5);
      rd(base);
      chk("prescaled count", 8'((((n + (1 << d) - 1) >> d) + 3) % 256), rd_val);
      wr(base + 8'h01, 8'h04);
      rd(base);
      chk("cleared count", 8'h00, rd_val);
      rd(base + 8'h01);
      chk("control after clear", 8'h00, rd_val);
    end
    for (int m = 0; m < 4; m++) begin
      reset_dut();
      cc = $urandom_range(2, 40);
      n = $urandom_range(1, 120);
      wr(DTC_TIMER_A_CH0_COMPARE_VALUE, 8'(cc));
      wr(DTC_TIMER_A_CONTROL, 8'h18 | 8'(m));
      ticks(n);
      rd(DTC_TIMER_A_COUNTER);
      chk("mode count", 8'(exp_count(m, cc, n)), rd_val);
      ovf = (m == 1) ? (n >= cc) : (m == 2) ? (n > cc) : (m == 3) ? (n >= 2 * cc) : 0;
      rd(DTC_TIMER_FLAGS_AND_MASK);
      v = 8'h40 | 8'(ovf) | ((m == 3 && ovf != 0) ? 8'h02 : 8'h00);
      chk("mode flags", v, rd_val);
    end
    reset_dut();
    wr(DTC_TIMER_A_CONTROL, 8'h18);
    ticks(258);
    rd(DTC_TIMER_A_COUNTER);
    chk("free wrap", 8'h02, rd_val);
    rd(DTC_TIMER_FLAGS_AND_MASK);
    chk("overflow flag", 8'h41, rd_val);
    chk("irq on", 8'h01, {7'h00, timer_a_irq});
    @(posedge mclk);
    cpu_a_en <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("irq cpu off", 8'h00, {7'h00, timer_a_irq});
    cpu_a_en <= 1'b1;
    wr(DTC_TIMER_A_CONTROL, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq masked", 8'h00, {7'h00, timer_a_irq});
    wr(DTC_TIMER_FLAGS_AND_MASK, 8'hFF);
    rd(DTC_TIMER_FLAGS_AND_MASK);
    chk("flag kept", 8'h41, rd_val);
    wr(DTC_TIMER_FLAGS_AND_MASK, 8'h40);
    rd(DTC_TIMER_FLAGS_AND_MASK);
    chk("flag cleared", 8'h40, rd_val);
    reset_dut();
    wr(DTC_TIMER_B_CH1_COMPARE_VALUE, 8'h03);
    wr(DTC_TIMER_B_CONTROL, 8'h10);
    ticks(3);
    chk("disabled pin", 8'h00, {6'h00, timer_b_cmp_out});
    rd(DTC_TIMER_FLAGS_AND_MASK);
    chk("disabled flag", 8'h40, rd_val);
    for (int a = 0; a < 3; a++) begin
      wr(DTC_TIMER_B_CONTROL, 8'h04);
      wr(DTC_TIMER_B_CH1_CONTROL, 8'h44 | 8'(a << 3));
      wr(DTC_TIMER_B_CONTROL, 8'h10);
      ticks(3);
      chk("compare pin", 8'(a != 1) << 1, {6'h00, timer_b_cmp_out});
    end
    chk("channel irq", 8'h01, {7'h00, timer_b_irq});
    wr(DTC_TIMER_B_CH1_CONTROL, 8'h14);
    repeat (2) @(posedge mclk);
    chk("channel irq masked", 8'h00, {7'h00, timer_b_irq});
    // Timer A pins in modulo and up/down mode; pins are {ch1, ch0}.
    reset_dut();
    wr(DTC_TIMER_A_CH0_COMPARE_VALUE, 8'h04);
    wr(DTC_TIMER_A_CH1_COMPARE_VALUE, 8'h02);
    wr(DTC_TIMER_A_CH0_CONTROL, 8'h5C);
    wr(DTC_TIMER_A_CH1_CONTROL, 8'h6C);
    wr(DTC_TIMER_A_CONTROL, 8'h12);
    ticks(3);
    chk("pins at 3", 8'h02, {6'h00, timer_a_cmp_out});
    ticks(1);
    chk("pins at 4", 8'h01, {6'h00, timer_a_cmp_out});
    // A new channel-0 value must wait for zero, so the period ends at 4 once more.
    wr(DTC_TIMER_A_CH0_COMPARE_VALUE, 8'h03);
    ticks(1);
    chk("pins at wrap", 8'h00, {6'h00, timer_a_cmp_out});
    wr(DTC_TIMER_A_CH0_CONTROL, 8'h64);
    wr(DTC_TIMER_A_CH1_CONTROL, 8'h74);
    ticks(3);
    chk("pins at new top", 8'h02, {6'h00, timer_a_cmp_out});
    ticks(1);
    chk("pins at zero", 8'h03, {6'h00, timer_a_cmp_out});
    wr(DTC_TIMER_A_CH1_CONTROL, 8'h5C);
    wr(DTC_TIMER_A_CONTROL, 8'h13);
    ticks(2);
    chk("pins going up", 8'h03, {6'h00, timer_a_cmp_out});
    ticks(2);
    chk("pins going down", 8'h00, {6'h00, timer_a_cmp_out});
    print_verdict();
  end
endmodule
